// >>> hbm_top.sv
/*
   H-bridge control logic of a brushed DC motor or solenoid driver.
   Assumes all inputs except clk_sys and rst are asynchronous pins and that the gate enables
   drive the high-side and low-side FETs of each output leg.
*/
// Overview of operation
// R1: Decode inputs: coast, reverse, forward when awake
// R2: Both inputs high: both outputs low, brake
// R3: Sleep low holds outputs off, stays dormant
// R4: Fast decay: off phase turns bridge off
// R5: Slow decay: off phase brakes the coil
// R6: Controller keeps input PWM at most 250 kHz
// R7: Drive starts only after 35 us wake
// R8: Inputs ignored in sleep; resume when high
// R9: Persistent overcurrent trips bridge, retries periodically
// R10: Overtemperature or undervoltage forces bridge off
// R11: Break-before-make dead time on each leg
`timescale 1ns/10ps
module hbm_top #(
   parameter int unsigned RETRY_CYC = hbm_pkg::RETRY_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sleep_bar_input,
   input wire logic direction_input_a,
   input wire logic direction_input_b,
   input wire logic overcurrent_guard,
   input wire logic thermal_shutdown_guard,
   input wire logic supply_low_lockout,
   output logic bridge_output_a_high_on,
   output logic bridge_output_a_low_on,
   output logic bridge_output_b_high_on,
   output logic bridge_output_b_low_on,
   output logic dormant
);
   localparam logic [hbm_pkg::CNT_W-1:0] WAKE_LD = hbm_pkg::CNT_W'(hbm_pkg::WAKE_CYC - 1);
   localparam logic [hbm_pkg::CNT_W-1:0] RETRY_LD = hbm_pkg::CNT_W'(RETRY_CYC - 1);
   localparam logic [hbm_pkg::DEG_W-1:0] DEG_LD = hbm_pkg::DEG_W'(hbm_pkg::DEG_CYC - 1);

   typedef struct packed {
      logic [hbm_pkg::NSYNC-1:0] s1;
      logic [hbm_pkg::NSYNC-1:0] s2;
      hbm_pkg::hbm_mode_t mode;
      logic [hbm_pkg::CNT_W-1:0] cnt;
      logic [hbm_pkg::DEG_W-1:0] deg;
   } hbm_top_st_t;

   hbm_top_st_t st_r;
   hbm_top_st_t st_nxt;
   hbm_pkg::hbm_drive_t req_a;
   hbm_pkg::hbm_drive_t req_b;
   logic in_a;
   logic in_b;
   logic sl;
   logic oc;
   logic fault;
   logic run_ok;

   // ---------------------------------------------------------------
   // Synchronised inputs
   // ---------------------------------------------------------------
   assign in_a = st_r.s2[hbm_pkg::IX_A];
   assign in_b = st_r.s2[hbm_pkg::IX_B];
   assign sl = st_r.s2[hbm_pkg::IX_SL];
   assign oc = st_r.s2[hbm_pkg::IX_OC];
   assign fault = st_r.s2[hbm_pkg::IX_TS] || st_r.s2[hbm_pkg::IX_UV];
   assign run_ok = (st_r.mode == hbm_pkg::HBM_RUN) && !fault;

   // ---------------------------------------------------------------
   // Mode sequencing
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {supply_low_lockout, thermal_shutdown_guard, overcurrent_guard,
                   sleep_bar_input, direction_input_b, direction_input_a};
      st_nxt.s2 = st_r.s1;
      case (st_r.mode)
         hbm_pkg::HBM_SLEEP: begin
            st_nxt.mode = hbm_pkg::HBM_WAKE; // R7
            st_nxt.cnt = WAKE_LD; // R7
         end
         hbm_pkg::HBM_WAKE: begin
            if (st_r.cnt == hbm_pkg::CNT_RST) begin
               st_nxt.mode = hbm_pkg::HBM_RUN; // R8
               st_nxt.deg = hbm_pkg::DEG_RST;
            end else begin
               st_nxt.cnt = st_r.cnt - 17'h00001;
            end
         end
         hbm_pkg::HBM_RUN: begin
            if (!oc) begin
               st_nxt.deg = hbm_pkg::DEG_RST;
            end else if (st_r.deg == DEG_LD) begin
               st_nxt.mode = hbm_pkg::HBM_TRIP; // R9
               st_nxt.cnt = RETRY_LD; // R9
               st_nxt.deg = hbm_pkg::DEG_RST;
            end else begin
               st_nxt.deg = st_r.deg + 8'h01;
            end
         end
         hbm_pkg::HBM_TRIP: begin
            if (st_r.cnt == hbm_pkg::CNT_RST) begin
               st_nxt.mode = hbm_pkg::HBM_RUN; // R9
            end else begin
               st_nxt.cnt = st_r.cnt - 17'h00001;
            end
         end
         default: begin
            st_nxt.mode = hbm_pkg::MODE_RST;
         end
      endcase
      // Sleep overrides everything, including a pending trip
      if (!sl) begin
         st_nxt.mode = hbm_pkg::HBM_SLEEP; // R3 R8
         st_nxt.cnt = hbm_pkg::CNT_RST;
         st_nxt.deg = hbm_pkg::DEG_RST;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r.s1 <= hbm_pkg::SYNC_RST;
         st_r.s2 <= hbm_pkg::SYNC_RST;
         st_r.mode <= hbm_pkg::MODE_RST;
         st_r.cnt <= hbm_pkg::CNT_RST;
         st_r.deg <= hbm_pkg::DEG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Direction decode
   // ---------------------------------------------------------------
   always_comb begin
      req_a = hbm_pkg::HBM_OFF;
      req_b = hbm_pkg::HBM_OFF;
      if (run_ok) begin // R3 R10
         case ({in_b, in_a})
            2'h1: begin
               req_a = hbm_pkg::HBM_HIGH; // R1
               req_b = hbm_pkg::HBM_LOW; // R1
            end
            2'h2: begin
               req_a = hbm_pkg::HBM_LOW; // R1
               req_b = hbm_pkg::HBM_HIGH; // R1
            end
            2'h3: begin
               req_a = hbm_pkg::HBM_LOW; // R2 R5
               req_b = hbm_pkg::HBM_LOW; // R2 R5
            end
            default: begin
               req_a = hbm_pkg::HBM_OFF; // R1 R4
               req_b = hbm_pkg::HBM_OFF; // R1 R4
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output legs
   // ---------------------------------------------------------------
   hbm_leg_if leg_if[2] ();

   generate
      for (genvar i = 0; i < 2; i++) begin : g_leg
         hbm_leg u_leg (
            .clk_sys(clk_sys),
            .rst(rst),
            .lg(leg_if[i])
         );
      end
   endgenerate

   assign leg_if[0].req = req_a;
   assign leg_if[1].req = req_b;
   assign bridge_output_a_high_on = leg_if[0].hs_on;
   assign bridge_output_a_low_on = leg_if[0].ls_on;
   assign bridge_output_b_high_on = leg_if[1].hs_on;
   assign bridge_output_b_low_on = leg_if[1].ls_on;
   assign dormant = (st_r.mode == hbm_pkg::HBM_SLEEP);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_fwd;
      (run_ok && in_a && !in_b) |-> (req_a == hbm_pkg::HBM_HIGH && req_b == hbm_pkg::HBM_LOW);
   endproperty
   a_fwd: assert property (p_fwd) else $error("Forward decode wrong"); // R1

   property p_rev_coast;
      run_ok |-> ((!in_a && in_b) ? (req_a == hbm_pkg::HBM_LOW && req_b == hbm_pkg::HBM_HIGH)
         : (!in_a && !in_b) ? (req_a == hbm_pkg::HBM_OFF && req_b == hbm_pkg::HBM_OFF) : 1'b1);
   endproperty
   a_rev_coast: assert property (p_rev_coast) else $error("Reverse or coast wrong"); // R1 R4

   property p_brake;
      (run_ok && in_a && in_b) |-> (req_a == hbm_pkg::HBM_LOW && req_b == hbm_pkg::HBM_LOW);
   endproperty
   a_brake: assert property (p_brake) else $error("Brake decode wrong"); // R2

   property p_sleep;
      !sl |=> (dormant && req_a == hbm_pkg::HBM_OFF && req_b == hbm_pkg::HBM_OFF);
   endproperty
   a_sleep: assert property (p_sleep) else $error("Sleep did not stop drive"); // R3

   property p_wake;
      (dormant && sl) |=> (st_r.mode == hbm_pkg::HBM_WAKE && st_r.cnt == WAKE_LD);
   endproperty
   a_wake: assert property (p_wake) else $error("Wake interval not loaded"); // R7

   property p_resume;
      (st_r.mode == hbm_pkg::HBM_WAKE && st_r.cnt == hbm_pkg::CNT_RST && sl)
         |=> st_r.mode == hbm_pkg::HBM_RUN;
   endproperty
   a_resume: assert property (p_resume) else $error("Did not resume after wake"); // R8

   property p_trip;
      (st_r.mode == hbm_pkg::HBM_RUN && oc && st_r.deg == DEG_LD && sl)
         |=> (st_r.mode == hbm_pkg::HBM_TRIP && st_r.cnt == RETRY_LD && req_a == hbm_pkg::HBM_OFF);
   endproperty
   a_trip: assert property (p_trip) else $error("Overcurrent trip wrong"); // R9

   property p_fault;
      fault |-> (req_a == hbm_pkg::HBM_OFF && req_b == hbm_pkg::HBM_OFF);
   endproperty
   a_fault: assert property (p_fault) else $error("Fault did not force off"); // R10

   c_fwd: cover property (run_ok && in_a && !in_b ##1 bridge_output_a_high_on);
   c_trip: cover property (st_r.mode == hbm_pkg::HBM_TRIP ##1 st_r.mode == hbm_pkg::HBM_RUN);
   c_brake: cover property (bridge_output_a_low_on && bridge_output_b_low_on);
endmodule

// >>> hbm_pkg.sv
/*
   Shared types and constants of the H-bridge control logic.
   Assumes a 50 MHz system clock; all timing counts derive from it.
*/
package hbm_pkg;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {HBM_OFF, HBM_HIGH, HBM_LOW} hbm_drive_t;
   typedef enum logic [1:0] {HBM_SLEEP, HBM_WAKE, HBM_RUN, HBM_TRIP} hbm_mode_t;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned WAKE_NS = 35000;
   localparam int unsigned DEG_NS = 3000;
   localparam int unsigned RETRY_NS = 1300000;
   localparam int unsigned DEAD_NS = 205;
   // Least times, rounded up to whole cycles
   localparam int unsigned WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned DEG_CYC = (DEG_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RETRY_CYC = (RETRY_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;

   // ---------------------------------------------------------------
   // Widths and field positions
   // ---------------------------------------------------------------
   localparam int unsigned CNT_W = 17;
   localparam int unsigned DEG_W = 8;
   localparam int unsigned DEAD_W = 4;
   localparam int unsigned NSYNC = 6;
   localparam int unsigned IX_A = 0;
   localparam int unsigned IX_B = 1;
   localparam int unsigned IX_SL = 2;
   localparam int unsigned IX_OC = 3;
   localparam int unsigned IX_TS = 4;
   localparam int unsigned IX_UV = 5;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam hbm_mode_t MODE_RST = HBM_SLEEP;
   localparam hbm_drive_t DRIVE_RST = HBM_OFF;
   localparam logic [NSYNC-1:0] SYNC_RST = 6'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 17'h00000;
   localparam logic [DEG_W-1:0] DEG_RST = 8'h00;
   localparam logic [DEAD_W-1:0] DEAD_RST = 4'h0;

endpackage

// >>> hbm_leg_if.sv
/*
   Carrier between the bridge controller and one output leg.
   Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface hbm_leg_if;
   hbm_pkg::hbm_drive_t req;
   logic hs_on;
   logic ls_on;
   modport ctl (output req, input hs_on, input ls_on);
   modport leg (input req, output hs_on, output ls_on);
endinterface

// >>> hbm_leg.sv
/*
   One bridge leg: turns the requested drive into gate enables with a
   break-before-make gap. Assumes a synchronous request on clk_sys.
*/
`timescale 1ns/10ps
module hbm_leg (
   input wire logic clk_sys,
   input wire logic rst,
   hbm_leg_if.leg lg
);
   localparam logic [hbm_pkg::DEAD_W-1:0] DEAD_LD = hbm_pkg::DEAD_W'(hbm_pkg::DEAD_CYC);

   typedef struct packed {
      hbm_pkg::hbm_drive_t cur;
      logic [hbm_pkg::DEAD_W-1:0] cnt;
   } hbm_leg_st_t;

   hbm_leg_st_t st_r;
   hbm_leg_st_t st_nxt;

   // ---------------------------------------------------------------
   // Dead-time sequencing
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      if (st_r.cur != hbm_pkg::HBM_OFF) begin
         if (lg.req != st_r.cur) begin
            st_nxt.cur = hbm_pkg::HBM_OFF; // R11
            st_nxt.cnt = DEAD_LD; // R11
         end
      end else if (st_r.cnt != hbm_pkg::DEAD_RST) begin
         st_nxt.cnt = st_r.cnt - 4'h1;
      end else begin
         st_nxt.cur = lg.req;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r.cur <= hbm_pkg::DRIVE_RST;
         st_r.cnt <= hbm_pkg::DEAD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lg.hs_on = (st_r.cur == hbm_pkg::HBM_HIGH);
   assign lg.ls_on = (st_r.cur == hbm_pkg::HBM_LOW);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_no_shoot;
      @(posedge clk_sys) disable iff (rst) !(lg.hs_on && lg.ls_on);
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("Leg shoot-through"); // R11

   property p_gap;
      @(posedge clk_sys) disable iff (rst)
         ($rose(lg.hs_on) || $rose(lg.ls_on)) |->
            ($past(st_r.cnt) == hbm_pkg::DEAD_RST && $past(st_r.cur) == hbm_pkg::HBM_OFF);
   endproperty
   a_gap: assert property (p_gap) else $error("Leg turned on inside dead time"); // R11

   property p_load;
      @(posedge clk_sys) disable iff (rst)
         (st_r.cur != hbm_pkg::HBM_OFF && lg.req != st_r.cur) |=>
            (!lg.hs_on && !lg.ls_on && st_r.cnt == DEAD_LD);
   endproperty
   a_load: assert property (p_load) else $error("Dead time not started"); // R11
endmodule

// >>> hbm_ctl_model.sv
/*
   Controller model: drives both direction pins, steady or as PWM.
   Assumes its commands change just after a falling edge of clk_sys.
*/
`timescale 1ns/10ps
module hbm_ctl_model #(
   parameter int unsigned PWM_CYC = 200
) (
   input wire logic clk_sys,
   input wire logic pwm_on,
   input wire logic slow,
   input wire logic level_a,
   input wire logic level_b,
   output logic direction_input_a,
   output logic direction_input_b
);
   int unsigned ph_cnt = 0;
   logic ph;

   // Period of 200 cycles keeps the rate at 250 kHz
   always @(negedge clk_sys) begin
      ph_cnt <= (ph_cnt + 1 >= PWM_CYC) ? 0 : ph_cnt + 1;
   end
   assign ph = ph_cnt < PWM_CYC / 2;

   // Forward PWM only; ph high is the drive phase
   always @(negedge clk_sys) begin
      if (!pwm_on) begin
         direction_input_a <= level_a;
         direction_input_b <= level_b;
      end else if (slow) begin
         direction_input_a <= 1'b1;
         direction_input_b <= ~ph;
      end else begin
         direction_input_a <= ph;
         direction_input_b <= 1'b0;
      end
   end
endmodule

// >>> tb_h_bridge_motor_control.sv
/*
   Self-checking bench of the H-bridge control logic.
   Assumes two synchroniser flops on every pin and one flop per gate.
*/
`timescale 1ns/10ps
module tb_h_bridge_motor_control;
   localparam logic [3:0] G_OFF = 4'h0;
   localparam logic [3:0] G_FWD = 4'h9;
   localparam logic [3:0] G_REV = 4'h6;
   localparam logic [3:0] G_BRK = 4'h5;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic sleep_bar_input = 1'b0;
   logic overcurrent_guard = 1'b0;
   logic thermal_shutdown_guard = 1'b0;
   logic supply_low_lockout = 1'b0;
   logic pwm_on = 1'b0;
   logic slow = 1'b0;
   logic level_a = 1'b0;
   logic level_b = 1'b0;
   logic direction_input_a;
   logic direction_input_b;
   logic ah, al, bh, bl, dormant;
   logic [3:0] gates;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   assign gates = {ah, al, bh, bl};

   hbm_top #(.RETRY_CYC(40)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .sleep_bar_input(sleep_bar_input),
      .direction_input_a(direction_input_a), .direction_input_b(direction_input_b),
      .overcurrent_guard(overcurrent_guard),
      .thermal_shutdown_guard(thermal_shutdown_guard),
      .supply_low_lockout(supply_low_lockout),
      .bridge_output_a_high_on(ah), .bridge_output_a_low_on(al),
      .bridge_output_b_high_on(bh), .bridge_output_b_low_on(bl), .dormant(dormant));

   hbm_ctl_model i_ctl (
      .clk_sys(clk_sys), .pwm_on(pwm_on), .slow(slow), .level_a(level_a),
      .level_b(level_b), .direction_input_a(direction_input_a),
      .direction_input_b(direction_input_b));

   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk_g(input logic [3:0] got, input logic [3:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic wait_g(input logic [3:0] exp, input int lim, output int n);
      n = 0;
      while (gates !== exp && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_sleep;
      chk_g(gates, G_OFF);
      chk_g({3'h0, dormant}, 4'h1);
      level_a <= 1'b1;
      cyc(10);
      chk_g(gates, G_OFF);
   endtask

   task automatic t_wake;
      int n;
      sleep_bar_input <= 1'b1;
      cyc(1);
      wait_g(G_FWD, 1800, n);
      chk_n(8'(n >= 1749 && n <= 1760), 8'h01);
      chk_g({3'h0, dormant}, 4'h0);
   endtask

   task automatic t_decode;
      logic [1:0] pin [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
      logic [3:0] exp [4] = '{G_OFF, G_BRK, G_REV, G_FWD};
      for (int i = 0; i < 4; i++) begin
         {level_a, level_b} <= pin[i];
         cyc(20);
         chk_g(gates, exp[i]);
      end
   endtask

   task automatic t_dead;
      int off_n = 0;
      {level_a, level_b} <= 2'h1;
      cyc(2);
      repeat (24) begin
         @(negedge clk_sys);
         if (!ah && !al) off_n++;
         if (ah && al) off_n += 16;
      end
      chk_n(8'(off_n), 8'(hbm_pkg::DEAD_CYC + 1));
      chk_g(gates, G_REV);
   endtask

   // Fast decay: 100 on, 100 off; slow loses the leg A gap per change
   task automatic t_pwm;
      logic [3:0] offs [2] = '{G_OFF, G_BRK};
      int on_n, off_n;
      for (int m = 0; m < 2; m++) begin
         on_n = 0;
         off_n = 0;
         slow <= m[0];
         pwm_on <= 1'b1;
         cyc(40);
         repeat (400) begin
            @(negedge clk_sys);
            if (gates === G_FWD) on_n++;
            if (gates === offs[m]) off_n++;
         end
         chk_n(8'(on_n), m ? 8'(200 - 2 * (hbm_pkg::DEAD_CYC + 1)) : 8'hc8);
         chk_n(8'(off_n), m ? 8'(200 - 2 * (hbm_pkg::DEAD_CYC + 1)) : 8'hc8);
      end
      pwm_on <= 1'b0;
      {level_a, level_b} <= 2'h2;
      cyc(30);
   endtask

   task automatic t_fault;
      int n;
      for (int f = 0; f < 2; f++) begin
         {thermal_shutdown_guard, supply_low_lockout} <= f ? 2'h1 : 2'h2;
         wait_g(G_OFF, 10, n);
         chk_n(8'(n), 8'h03);
         cyc(50);
         chk_g(gates, G_OFF);
         {thermal_shutdown_guard, supply_low_lockout} <= 2'h0;
         wait_g(G_FWD, 30, n);
         chk_n(8'(n), 8'h03);
      end
   endtask

   task automatic t_ocp;
      int n;
      overcurrent_guard <= 1'b1;
      wait_g(G_OFF, 300, n);
      chk_n(8'(n >= 150 && n <= 156), 8'h01);
      wait_g(G_FWD, 100, n);
      chk_n(8'(n >= 40 && n <= 44), 8'h01);
      wait_g(G_OFF, 300, n);
      chk_n(8'(n >= 148 && n <= 156), 8'h01);
      overcurrent_guard <= 1'b0;
      cyc(150);
      chk_g(gates, G_FWD);
   endtask

   task automatic t_resleep;
      int n;
      sleep_bar_input <= 1'b0;
      wait_g(G_OFF, 10, n);
      chk_n(8'(n), 8'h04);
      chk_g({3'h0, dormant}, 4'h1);
      {level_a, level_b} <= 2'h1;
      cyc(20);
      chk_g(gates, G_OFF);
   endtask

   always @(negedge clk_sys) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      t_sleep();
      t_wake();
      t_decode();
      t_dead();
      {level_a, level_b} <= 2'h2;
      cyc(20);
      t_pwm();
      t_fault();
      t_ocp();
      t_resleep();
      stop_test();
   end
endmodule
